// ==== rtl/pdpu_pkg.sv ====
package pdpu_pkg;

  localparam int ADDR_W = 22;
  localparam int IDX_W = 20;
  localparam int NGRP = 5;
  localparam int NPU = 3;
  localparam int NPIN = NGRP * 8;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] PU_GRP1_IDX = 20'hF0031;
  localparam logic [IDX_W-1:0] PU_GRP3_IDX = 20'hF0033;
  localparam logic [IDX_W-1:0] PU_GRP4_IDX = 20'hF0034;
  localparam logic [IDX_W-1:0] PD_GRP1_IDX = 20'hFFF01;
  localparam logic [IDX_W-1:0] PD_GRP2_IDX = 20'hFFF02;
  localparam logic [IDX_W-1:0] PD_GRP3_IDX = 20'hFFF03;
  localparam logic [IDX_W-1:0] PD_GRP4_IDX = 20'hFFF04;
  localparam logic [IDX_W-1:0] PD_GRP6_IDX = 20'hFFF06;
  localparam logic [IDX_W-1:0] PD_GRP12_IDX = 20'hFFF0C;
  localparam logic [IDX_W-1:0] PD_GRP13_IDX = 20'hFFF0D;

  // writable port groups in order 1,2,3,4,6
  localparam logic [NGRP-1:0][IDX_W-1:0] PD_IDX =
    {PD_GRP6_IDX, PD_GRP4_IDX, PD_GRP3_IDX, PD_GRP2_IDX, PD_GRP1_IDX};
  localparam logic [NGRP-1:0][7:0] PD_MASK_FULL = {8'h03, 8'h01, 8'h3F, 8'hFF, 8'hFF};
  localparam logic [NGRP-1:0][7:0] PD_MASK_SMALL = {8'h03, 8'h01, 8'h0F, 8'h8F, 8'h6D};
  localparam logic [7:0] PD_RST = 8'h00;

  // pull-up groups 1,3,4 and the port group each one serves
  localparam logic [NPU-1:0][IDX_W-1:0] PU_IDX = {PU_GRP4_IDX, PU_GRP3_IDX, PU_GRP1_IDX};
  localparam logic [NPU-1:0][2:0] PU_GRP_MAP = {3'h3, 3'h2, 3'h0};
  localparam logic [NPU-1:0][7:0] PU_MASK_FULL = {8'h01, 8'h3F, 8'hFF};
  localparam logic [NPU-1:0][7:0] PU_MASK_SMALL = {8'h01, 8'h0F, 8'h6D};
  localparam logic [NPU-1:0][7:0] PU_RST = {8'h01, 8'h00, 8'h00};

  // input-only pins a,b in group 12 bits 1,2; pin c in group 13 bit 7
  localparam int RO_A_POS = 1;
  localparam int RO_B_POS = 2;
  localparam int RO_C_POS = 7;
  localparam int ANALOG_GRP = 1;
  localparam int ANALOG_SEL_POS = 0;

  // single-bit write format
  localparam int BIT_WR_POS = 31;
  localparam int BIT_IDX_LSB = 8;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    PDPU_IDLE = 2'b01,
    PDPU_ACK = 2'b10
  } pdpu_bus_e;

endpackage

// ==== rtl/pdpu_port_regs.sv ====
`timescale 1ns/1ps
module pdpu_port_regs
  import pdpu_pkg::*;
#(
  parameter bit SMALL_PKG = 1'b0
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic [ADDR_W-1:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  input wire logic [NPIN-1:0] pin_level_in,
  input wire logic [2:0] input_only_pin_in,
  input wire logic [NPIN-1:0] pin_direction_bit_in,
  input wire logic [NPIN-1:0] alt_out_active_in,
  input wire logic [7:0] analog_port_config_in,
  input wire logic analog_pin_select_in,
  output logic [NPIN-1:0] pin_out_out,
  output logic [NPIN-1:0] pin_oe_out,
  output logic [NPIN-1:0] pullup_en_out
);

  localparam logic [NGRP-1:0][7:0] PD_MASK = SMALL_PKG ? PD_MASK_SMALL : PD_MASK_FULL;
  localparam logic [NPU-1:0][7:0] PU_MASK = SMALL_PKG ? PU_MASK_SMALL : PU_MASK_FULL;

  pdpu_bus_e state_r, state_nxt;
  logic [NGRP-1:0][7:0] port_lat_r, port_lat_nxt;
  logic [NPU-1:0][7:0] pu_sel_r, pu_sel_nxt;
  logic [31:0] readdata_r, readdata_nxt;
  logic [NPIN-1:0] pin_s1_r, pin_s2_r;
  logic [2:0] ro_s1_r, ro_s2_r;
  logic [NPIN-1:0] pin_mask;
  logic [NPIN-1:0] analog_rd_zero;
  logic [NPIN-1:0] pu_req;
  logic [IDX_W-1:0] idx;
  logic req;
  logic bit_mode;
  logic [2:0] bit_idx;

  assign idx = address_in[ADDR_W-1:2];
  assign req = read_in | write_in;
  assign bit_mode = writedata_in[BIT_WR_POS];
  assign bit_idx = writedata_in[BIT_IDX_LSB +: 3];
  // no acknowledge while the clock enable freezes the state
  assign waitrequest_out = req & ~(state_r == PDPU_ACK && clk_en_in);
  assign readdata_out = readdata_r;

  // merge a byte or single-bit write into an old value
  function automatic logic [7:0] merge_wr(input logic [7:0] old, input logic [7:0] mask);
    logic [7:0] nv;
    nv = writedata_in[7:0];
    if (bit_mode) begin
      nv = old;
      nv[bit_idx] = writedata_in[0];
    end
    merge_wr = nv & mask;
  endfunction

  // per-pin side conditions
  always_comb begin
    analog_rd_zero = '0;
    pu_req = '0;
    for (int g = 0; g < NGRP; g++) begin
      pin_mask[g*8 +: 8] = PD_MASK[g];
    end
    analog_rd_zero[ANALOG_GRP*8 +: 8] = ~analog_port_config_in;
    for (int p = 0; p < NPU; p++) begin
      pu_req[PU_GRP_MAP[p]*8 +: 8] = pu_sel_r[p];
    end
  end

  // pin side: latch drives pin only in output mode
  always_comb begin
    pin_out_out = port_lat_r;
    pin_oe_out = ~pin_direction_bit_in & pin_mask;
    pullup_en_out = pu_req & pin_direction_bit_in & ~alt_out_active_in & pin_mask;
    if (analog_pin_select_in) begin
      pullup_en_out[ANALOG_SEL_POS] = 1'b0;
    end
  end

  // read value of a port data group
  function automatic logic [7:0] pd_read(input int g);
    logic [7:0] v;
    for (int b = 0; b < 8; b++) begin
      if (pin_direction_bit_in[g*8+b]) begin
        v[b] = pin_s2_r[g*8+b] & ~analog_rd_zero[g*8+b];
      end else begin
        v[b] = port_lat_r[g][b];
      end
    end
    pd_read = v & PD_MASK[g];
  endfunction

  // register index decode
  function automatic logic pd_hit(input int g);
    pd_hit = idx == PD_IDX[g];
  endfunction

  function automatic logic pu_hit(input int p);
    pu_hit = idx == PU_IDX[p];
  endfunction

  // bus handshake and register updates
  always_comb begin
    state_nxt = state_r;
    port_lat_nxt = port_lat_r;
    pu_sel_nxt = pu_sel_r;
    readdata_nxt = readdata_r;
    unique case (state_r)
      PDPU_IDLE: begin
        if (req) begin
          state_nxt = PDPU_ACK;
          readdata_nxt = RD_ZERO;
          if (read_in) begin
            for (int g = 0; g < NGRP; g++) begin
              if (pd_hit(g)) begin
                readdata_nxt[7:0] = pd_read(g);
              end
            end
            for (int p = 0; p < NPU; p++) begin
              if (pu_hit(p)) begin
                readdata_nxt[7:0] = pu_sel_r[p];
              end
            end
            if (idx == PD_GRP12_IDX) begin
              readdata_nxt[RO_A_POS] = ro_s2_r[0];
              readdata_nxt[RO_B_POS] = ro_s2_r[1];
            end
            if (idx == PD_GRP13_IDX) begin
              readdata_nxt[RO_C_POS] = ro_s2_r[2];
            end
          end
        end
      end
      PDPU_ACK: begin
        state_nxt = PDPU_IDLE;
        if (write_in) begin
          for (int g = 0; g < NGRP; g++) begin
            if (pd_hit(g)) begin
              port_lat_nxt[g] = merge_wr(port_lat_r[g], PD_MASK[g]);
            end
          end
          for (int p = 0; p < NPU; p++) begin
            if (pu_hit(p)) begin
              pu_sel_nxt[p] = merge_wr(pu_sel_r[p], PU_MASK[p]);
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= PDPU_IDLE;
      port_lat_r <= {NGRP{PD_RST}};
      pu_sel_r <= PU_RST;
      readdata_r <= RD_ZERO;
    end else if (clk_en_in) begin
      state_r <= state_nxt;
      port_lat_r <= port_lat_nxt;
      pu_sel_r <= pu_sel_nxt;
      readdata_r <= readdata_nxt;
    end
  end

  // two-stage synchronisers for pin levels
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      ro_s1_r <= '0;
      ro_s2_r <= '0;
    end else if (clk_en_in) begin
      pin_s1_r <= pin_level_in;
      pin_s2_r <= pin_s1_r;
      ro_s1_r <= input_only_pin_in;
      ro_s2_r <= ro_s1_r;
    end
  end

  // checks
  sequence s_rd_req(logic [IDX_W-1:0] ri);
    state_r == PDPU_IDLE && read_in && clk_en_in && idx == ri;
  endsequence

  sequence s_wr_done(logic [IDX_W-1:0] ri);
    state_r == PDPU_ACK && write_in && clk_en_in && idx == ri;
  endsequence

  property p_wr_byte;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    s_wr_done(PD_GRP1_IDX) and !bit_mode
      |=> port_lat_r[0] == ($past(writedata_in[7:0]) & PD_MASK[0]);
  endproperty
  a_wr_byte: assert property (p_wr_byte) else $error("port latch byte write lost");

  property p_rd_input;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    s_rd_req(PD_GRP3_IDX) and pin_direction_bit_in[23:16] == 8'hFF
      |=> readdata_out[7:0] == ($past(pin_s2_r[23:16]) & PD_MASK[2]);
  endproperty
  a_rd_input: assert property (p_rd_input) else $error("input read not pin level");

  property p_rd_output;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    s_rd_req(PD_GRP1_IDX) and pin_direction_bit_in[7:0] == 8'h00
      |=> readdata_out[7:0] == $past(port_lat_r[0]);
  endproperty
  a_rd_output: assert property (p_rd_output) else $error("output read not latch");

  property p_bit_wr;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    s_wr_done(PD_GRP2_IDX) and bit_mode
      |=> (port_lat_r[1] | (8'h01 << $past(bit_idx)))
          == ($past(port_lat_r[1]) | (8'h01 << $past(bit_idx)));
  endproperty
  a_bit_wr: assert property (p_bit_wr) else $error("bit write touched other bits");

  property p_rst_val;
    @(posedge core_clk_in)
    !rst_b_in |=> port_lat_r == '0 && pu_sel_r[0] == 8'h00 && pu_sel_r[1] == 8'h00;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("reset values wrong");

  property p_analog_zero;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    s_rd_req(PD_GRP2_IDX) and pin_direction_bit_in[15:8] == 8'hFF
      |=> (readdata_out[7:0] & ~$past(analog_port_config_in)) == 8'h00;
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero");

  property p_ro_write;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    s_wr_done(PD_GRP12_IDX) or s_wr_done(PD_GRP13_IDX)
      |=> $stable(port_lat_r) && $stable(pu_sel_r);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write had effect");

  property p_pullup;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (pullup_en_out & ~(pin_direction_bit_in & ~alt_out_active_in & pu_req)) == '0;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on non-input pin");

  property p_oe;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (pin_oe_out & pin_direction_bit_in) == '0;
  endproperty
  a_oe: assert property (p_oe) else $error("buffer on in input mode");

  property p_unimpl;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    s_rd_req(PD_GRP3_IDX) |=> readdata_out[31:8] == 24'h0 && (readdata_out[7:0] & ~PD_MASK[2]) == 8'h00;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bits nonzero");

  property p_rst_pu4;
    @(posedge core_clk_in)
    !rst_b_in |=> pu_sel_r[2] == 8'h01;
  endproperty
  a_rst_pu4: assert property (p_rst_pu4) else $error("group four pull-up reset wrong");

  property p_pin_latch;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    s_wr_done(PD_GRP1_IDX) and !bit_mode
      |=> pin_out_out[7:0] == ($past(writedata_in[7:0]) & PD_MASK[0]);
  endproperty
  a_pin_latch: assert property (p_pin_latch) else $error("latch not on pin output");

  property p_pu_off;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (pullup_en_out[7:0] & ~pu_sel_r[0]) == 8'h00;
  endproperty
  a_pu_off: assert property (p_pu_off) else $error("pull-up without select bit");

  property p_impl_mask;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (port_lat_r[0] & ~PD_MASK[0]) == 8'h00 && (pu_sel_r[0] & ~PU_MASK[0]) == 8'h00;
  endproperty
  a_impl_mask: assert property (p_impl_mask) else $error("absent bit holds a one");

  property p_analog_pu;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    analog_pin_select_in |-> !pullup_en_out[ANALOG_SEL_POS];
  endproperty
  a_analog_pu: assert property (p_analog_pu) else $error("pull-up on analog pin");

  sequence s_stall;
    req && !clk_en_in;
  endsequence

  property p_stall;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    s_stall |-> waitrequest_out;
  endproperty
  a_stall: assert property (p_stall) else $error("acknowledge while frozen");

  property p_rd_ro;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    s_rd_req(PD_GRP12_IDX)
      |=> readdata_out == {29'h0, $past(ro_s2_r[1:0]), 1'b0};
  endproperty
  a_rd_ro: assert property (p_rd_ro) else $error("input-only read wrong");

  property p_ack_once;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    state_r == PDPU_ACK && clk_en_in |=> state_r == PDPU_IDLE;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("acknowledge held too long");

  property p_oe_out;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (~pin_direction_bit_in & pin_mask & ~pin_oe_out) == '0;
  endproperty
  a_oe_out: assert property (p_oe_out) else $error("buffer off in output mode");

  property p_wr_pu;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    s_wr_done(PU_GRP3_IDX) and bit_mode
      |=> (pu_sel_r[1] | (8'h01 << $past(bit_idx)))
          == ($past(pu_sel_r[1]) | (8'h01 << $past(bit_idx)));
  endproperty
  a_wr_pu: assert property (p_wr_pu) else $error("pull-up bit write touched others");

endmodule

// ==== tb/pdpu_pin_board.sv ====
`timescale 1ns/1ps
module pdpu_pin_board
  import pdpu_pkg::*;
(
  input wire logic clk_in,
  input wire logic [NPIN-1:0] pin_out_in,
  input wire logic [NPIN-1:0] pin_oe_in,
  input wire logic [NPIN-1:0] pullup_en_in,
  input wire logic [NPIN-1:0] ext_val_in,
  input wire logic [NPIN-1:0] ext_drv_in,
  output logic [NPIN-1:0] level_out
);
  logic [NPIN-1:0] flt_r = '0;
  logic [NPIN-1:0] drvn;

  // undriven pin without pull-up shows the inverse of its last driven level
  assign drvn = pin_oe_in | ext_drv_in;
  always_ff @(posedge clk_in) begin
    flt_r <= (drvn & ~level_out) | (~drvn & flt_r);
  end

  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pin_oe_in[i]) begin
        level_out[i] = pin_out_in[i];
      end else if (ext_drv_in[i]) begin
        level_out[i] = ext_val_in[i];
      end else if (pullup_en_in[i]) begin
        level_out[i] = 1'b1;
      end else begin
        level_out[i] = flt_r[i];
      end
    end
  end
endmodule

// ==== tb/pdpu_port_regs_tb.sv ====
`timescale 1ns/1ps
module pdpu_port_regs_tb
  import pdpu_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic [31:0] got;
  logic [31:0] rdata_small;
  logic [31:0] got_small;
  logic wait_rq;
  logic [2:0] ro_pin = '0;
  logic [7:0] adc_cfg = 8'hFF;
  logic an_sel = 1'b0;
  logic [NPIN-1:0] dir = '0;
  logic [NPIN-1:0] alt = '0;
  logic [NPIN-1:0] ext = 40'h5A_C3_96_3C_E1;
  logic [NPIN-1:0] drv = '1;
  logic [NPIN-1:0] lvl;
  logic [NPIN-1:0] pout;
  logic [NPIN-1:0] oe;
  logic [NPIN-1:0] pu;
  int miscompares = 0;
  int n_checks = 0;

  always #20 clk = ~clk;

  pdpu_port_regs uut (
    .core_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(clk_en), .address_in(addr),
    .read_in(rd), .write_in(wr), .writedata_in(wdata), .readdata_out(rdata),
    .waitrequest_out(wait_rq), .pin_level_in(lvl), .input_only_pin_in(ro_pin),
    .pin_direction_bit_in(dir), .alt_out_active_in(alt), .analog_port_config_in(adc_cfg),
    .analog_pin_select_in(an_sel), .pin_out_out(pout), .pin_oe_out(oe), .pullup_en_out(pu)
  );

  pdpu_port_regs #(.SMALL_PKG(1'b1)) uut_small (
    .core_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(clk_en), .address_in(addr),
    .read_in(rd), .write_in(wr), .writedata_in(wdata), .readdata_out(rdata_small),
    .waitrequest_out(), .pin_level_in(lvl), .input_only_pin_in(ro_pin),
    .pin_direction_bit_in(dir), .alt_out_active_in(alt), .analog_port_config_in(adc_cfg),
    .analog_pin_select_in(an_sel), .pin_out_out(), .pin_oe_out(), .pullup_en_out()
  );

  pdpu_pin_board board (
    .clk_in(clk), .pin_out_in(pout), .pin_oe_in(oe), .pullup_en_in(pu),
    .ext_val_in(ext), .ext_drv_in(drv), .level_out(lvl)
  );

  task automatic xfer(input logic [IDX_W-1:0] idx, input logic w, input logic [31:0] d);
    @(posedge clk);
    addr <= {idx, 2'b00};
    rd <= ~w;
    wr <= w;
    wdata <= d;
    @(posedge clk);
    while (wait_rq !== 1'b0) begin
      @(posedge clk);
    end
    got = rdata;
    got_small = rdata_small;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rdc(input logic [IDX_W-1:0] idx, input logic [31:0] e);
    xfer(idx, 1'b0, '0);
    chk(got, e);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
  endtask

  task close_out;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    close_out;
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    for (int g = 0; g < NGRP; g++) rdc(PD_IDX[g], '0);
    for (int k = 0; k < NPU; k++) rdc(PU_IDX[k], (k == 2) ? 32'h01 : 32'h00);
    $display("test reset done");
    for (int g = 0; g < NGRP; g++) begin
      xfer(PD_IDX[g], 1'b1, 32'hA5);
      rdc(PD_IDX[g], {24'h0, 8'hA5 & PD_MASK_FULL[g]});
      chk(got_small, {24'h0, 8'hA5 & PD_MASK_SMALL[g]});
      chk({24'h0, pout[g*8+:8]}, {24'h0, 8'hA5 & PD_MASK_FULL[g]});
      chk({24'h0, oe[g*8+:8]}, {24'h0, PD_MASK_FULL[g]});
    end
    xfer(PD_GRP1_IDX, 1'b1, 32'h8000_0301);
    xfer(PD_GRP1_IDX, 1'b1, 32'h8000_0000);
    rdc(PD_GRP1_IDX, 32'hAC);
    $display("test write done");
    dir <= '1;
    settle;
    for (int g = 0; g < NGRP; g++) rdc(PD_IDX[g], {24'h0, ext[g*8+:8] & PD_MASK_FULL[g]});
    xfer(PD_GRP1_IDX, 1'b1, 32'h3C);
    @(posedge clk);
    chk({24'h0, pout[7:0]}, 32'h3C);
    chk({24'h0, oe[7:0]}, 32'h0);
    adc_cfg <= 8'h0F;
    settle;
    rdc(PD_GRP2_IDX, {24'h0, ext[15:8] & 8'h0F});
    dir <= '0;
    settle;
    rdc(PD_GRP1_IDX, 32'h3C);
    rdc(PD_GRP2_IDX, 32'hA5);
    $display("test read done");
    fork
      xfer(PD_GRP2_IDX, 1'b1, 32'h5A);
      begin
        repeat (2) @(posedge clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge clk);
        clk_en <= 1'b1;
      end
    join
    rdc(PD_GRP2_IDX, 32'h5A);
    xfer(PD_GRP2_IDX, 1'b1, 32'h8000_0701);
    rdc(PD_GRP2_IDX, 32'hDA);
    $display("test clock enable done");
    ro_pin <= 3'b101;
    settle;
    xfer(PD_GRP12_IDX, 1'b1, 32'hFF);
    rdc(PD_GRP12_IDX, 32'h02);
    rdc(PD_GRP13_IDX, 32'h80);
    rdc(20'h00010, 32'h0);
    $display("test read-only done");
    dir <= 40'hFF_FF_FF_FF_F1;
    alt <= 40'h30;
    an_sel <= 1'b1;
    drv <= '0;
    xfer(PU_GRP1_IDX, 1'b1, 32'hFF);
    xfer(PU_GRP3_IDX, 1'b1, 32'h8000_0501);
    rdc(PU_GRP3_IDX, 32'h20);
    chk(pu[31:0], 32'h0120_00C0);
    chk({24'h0, pu[39:32]}, 32'h0);
    xfer(PD_GRP3_IDX, 1'b0, '0);
    chk(got & 32'h20, 32'h20);
    xfer(PU_GRP1_IDX, 1'b1, 32'h00);
    @(posedge clk);
    chk({24'h0, pu[7:0]}, 32'h0);
    $display("test pull-up done");
    close_out;
  end
endmodule
